// >>> inc/ddsc_pkg.sv
// Constants for the memory-side command, address and control decoder.
// Assumes all pins are sampled by the local 20 MHz clock.
package ddsc_pkg;
  // ****************************************
  // Widths and counts
  // ****************************************
  localparam int ADDR_W      = 16;
  localparam int BA_W        = 3;
  localparam int NUM_BANKS   = 8;
  localparam int NUM_MR      = 4;
  localparam int COL_W       = 10;
  localparam int SYNC_STAGES = 2;
  // ****************************************
  // Address field positions
  // ****************************************
  localparam int A_AUTOPRE   = 10;
  localparam int A_BCHOP     = 12;
  localparam int MR0_BL_LSB  = 0;
  localparam int MR1_RTT_B0  = 2;
  localparam int MR1_RTT_B1  = 6;
  localparam int MR1_RTT_B2  = 9;
  // ****************************************
  // Burst length field and crossing counts
  // ****************************************
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF    = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam logic [2:0] BEATS_BL8 = 3'h4;
  localparam logic [2:0] BEATS_BC4 = 3'h2;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [ADDR_W-1:0]    MR_RST   = 16'h0000;
  localparam logic [NUM_BANKS-1:0] OPEN_RST = 8'h00;
  // ****************************************
  // Command codes {ras_n, cas_n, we_n} with cs_n low
  // ****************************************
  typedef enum logic [2:0] {
    CMD_MRS = 3'h0,
    CMD_REF = 3'h1,
    CMD_PRE = 3'h2,
    CMD_ACT = 3'h3,
    CMD_WR  = 3'h4,
    CMD_RD  = 3'h5,
    CMD_ZQ  = 3'h6,
    CMD_NOP = 3'h7
  } ddsc_cmd_t;
  typedef enum logic [1:0] {
    PW_ACT = 2'h0,
    PW_PD  = 2'h1,
    PW_SR  = 2'h2
  } ddsc_pwr_t;
endpackage

// >>> hw/ddsc_sync.sv
// Two-flop synchroniser for a bundle of pins.
// Assumes each bit is a slow level relative to clk.
`timescale 1ns/1ps
`default_nettype none
module ddsc_sync
  import ddsc_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // Data
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  always_comb begin
    meta_d = d;
    q_d    = meta_q;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= meta_d;
      q      <= q_d;
    end
  end
endmodule
`default_nettype wire

// >>> hw/ddsc_top.sv
// Memory-side decoder of DDR3 command, address and control pins.
// Assumes the controller drives all pins; the bench ck period is 450 ns.
// Function
// RULE1: ACTIVATE takes row from address; READ/WRITE take column and A10 auto-precharge.
// RULE2: PRECHARGE with A10 low closes bank BA; A10 high closes all banks.
// RULE3: LOAD MODE takes the opcode from the address inputs.
// RULE4: With on-the-fly chop enabled, A12 high gives BL8, low gives BC4.
// RULE5: Controller names the bank on BA; command touches that bank only.
// RULE6: LOAD MODE uses BA to pick mode register zero to three.
// RULE7: Inputs sampled where ck rises and ck_n falls.
// RULE8: Output data strobe aligned to the clock crossings.
// RULE9: Clock enable low enters power-down or self refresh, high enables.
// RULE10: Clock enable is synchronous except for self-refresh exit.
// RULE11: Power-down keeps only clocks, cke, reset, odt; self refresh only cke.
// RULE12: Commands accepted only with chip select registered low.
// RULE13: Controller treats chip select as part of the command code.
// RULE14: Write beats with mask sampled high are not stored.
// RULE15: Termination control high switches termination on, low off.
// RULE16: Termination only on data pins; ignored when disabled by mode register.
// RULE17: Controller drives a single sixteen-bit device.
// RULE18: Controller runs the interface at 400 MHz.
// RULE19: Controller encodes commands by cs_n, ras_n, cas_n, we_n levels.
`timescale 1ns/1ps
`default_nettype none
module ddsc_top
  import ddsc_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 resetn,
  // Memory pins from the controller
  input  wire logic                 ck,
  input  wire logic                 ck_n,
  input  wire logic                 cke,
  input  wire logic                 cs_n,
  input  wire logic                 ras_n,
  input  wire logic                 cas_n,
  input  wire logic                 we_n,
  input  wire logic                 odt,
  input  wire logic                 dm,
  input  wire logic [BA_W-1:0]      ba,
  input  wire logic [ADDR_W-1:0]    addr,
  // Decoded command
  output var  logic                 cmd_valid,
  output var  logic [2:0]           cmd_code,
  output var  logic [BA_W-1:0]      cmd_bank,
  output var  logic [ADDR_W-1:0]    cmd_row,
  output var  logic [COL_W-1:0]     cmd_col,
  output var  logic                 cmd_auto_pre,
  output var  logic                 cmd_bl8,
  output var  logic                 pre_all,
  output var  logic [NUM_BANKS-1:0] open_banks,
  // Mode register load
  output var  logic                 mr_wr,
  output var  logic [1:0]           mr_idx,
  output var  logic [ADDR_W-1:0]    mr_op,
  // Power, termination, strobe, write beats
  output var  logic [1:0]           pwr_state,
  output var  logic                 cke_int,
  output var  logic                 odt_on,
  output var  logic                 dqs,
  output var  logic                 dqs_n,
  output var  logic                 dqs_oe,
  output var  logic                 wr_store,
  output var  logic                 wr_masked
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int PIN_W = 9 + BA_W + ADDR_W;
  logic [PIN_W-1:0]  pins_s;
  logic              ck_s, ckn_s, cke_s, cs_s, ras_s, cas_s, we_s, odt_s, dm_s;
  logic [BA_W-1:0]   ba_s;
  logic [ADDR_W-1:0] addr_s;

  ddsc_sync #(.W(PIN_W)) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .d      ({ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, odt, dm, ba, addr}),
    .q      (pins_s)
  );
  assign {ck_s, ckn_s, cke_s, cs_s, ras_s, cas_s, we_s, odt_s, dm_s, ba_s, addr_s} = pins_s;

  // ****************************************
  // Crossing detection
  // ****************************************
  logic ck_prev_q;
  logic rise;
  logic fall;
  assign rise = ck_s & ~ck_prev_q & ~ckn_s; // RULE7
  assign fall = ~ck_s & ck_prev_q & ckn_s;

  // ****************************************
  // State
  // ****************************************
  logic [ADDR_W-1:0]    mr_q [NUM_MR];
  logic [ADDR_W-1:0]    mr_d [NUM_MR];
  logic [NUM_BANKS-1:0] open_q, open_d;
  ddsc_pwr_t            pw_q, pw_d;
  logic [2:0]           beats_q, beats_d;
  logic                 rd_q, rd_d;
  logic                 cke_q, cke_d;
  logic                 odt_q, odt_d;
  logic                 dqs_q, dqs_d;
  logic                 v_d, ap_d, bl8_d, pa_d, mrw_d, ws_d, wm_d;
  logic [2:0]           code_d;
  logic [BA_W-1:0]      bank_d;
  logic [ADDR_W-1:0]    row_d;
  logic [COL_W-1:0]     col_d;
  logic                 rtt_en;
  logic                 chop;
  ddsc_cmd_t            code;

  assign code   = ddsc_cmd_t'({ras_s, cas_s, we_s}); // RULE19
  assign rtt_en = mr_q[1][MR1_RTT_B0] | mr_q[1][MR1_RTT_B1] | mr_q[1][MR1_RTT_B2];
  always_comb begin
    unique case (mr_q[0][MR0_BL_LSB +: 2])
      BL_OTF:    chop = ~addr_s[A_BCHOP]; // RULE4
      BL_FIXED4: chop = 1'b1;
      default:   chop = 1'b0;
    endcase
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    mr_d    = mr_q;
    open_d  = open_q;
    pw_d    = pw_q;
    beats_d = beats_q;
    rd_d    = rd_q;
    cke_d   = cke_q;
    odt_d   = odt_q;
    dqs_d   = dqs_q;
    v_d     = 1'b0;
    mrw_d   = 1'b0;
    ws_d    = 1'b0;
    wm_d    = 1'b0;
    code_d  = cmd_code;
    bank_d  = cmd_bank;
    row_d   = cmd_row;
    col_d   = cmd_col;
    ap_d    = cmd_auto_pre;
    bl8_d   = cmd_bl8;
    pa_d    = pre_all;
    if (pw_q == PW_SR && cke_s) begin
      pw_d  = PW_ACT; // RULE10
      cke_d = 1'b1;
    end
    if (fall && dqs_q) begin
      dqs_d = 1'b0; // RULE8
    end
    if (rise) begin
      if (beats_q != 3'h0) begin
        beats_d = beats_q - 3'h1;
        if (rd_q) begin
          dqs_d = 1'b1; // RULE8
        end else begin
          ws_d = ~dm_s; // RULE14
          wm_d = dm_s; // RULE14
        end
      end
      if (pw_q != PW_SR) begin
        odt_d = odt_s & rtt_en; // RULE11 RULE15 RULE16
      end
      unique case (pw_q)
        PW_ACT: begin
          cke_d = cke_s; // RULE9
          if (!cke_s) begin
            if (!cs_s && code == CMD_REF && open_q == OPEN_RST) begin
              pw_d  = PW_SR; // RULE9 RULE10
              odt_d = 1'b0;
            end else begin
              pw_d = PW_PD; // RULE9
            end
          end else if (!cs_s) begin // RULE12
            v_d    = (code != CMD_NOP);
            code_d = code;
            bank_d = ba_s;
            unique case (code)
              CMD_MRS: begin
                mr_d[ba_s[1:0]] = addr_s; // RULE3 RULE6
                mrw_d = 1'b1;
                if (ba_s[1:0] == 2'h1) begin
                  odt_d = odt_s & (addr_s[MR1_RTT_B0] | addr_s[MR1_RTT_B1] | addr_s[MR1_RTT_B2]); // RULE16
                end
              end
              CMD_PRE: begin
                pa_d = addr_s[A_AUTOPRE]; // RULE2
                if (addr_s[A_AUTOPRE]) begin
                  open_d = OPEN_RST; // RULE2
                end else begin
                  open_d[ba_s] = 1'b0; // RULE2 RULE5
                end
              end
              CMD_ACT: begin
                row_d        = addr_s; // RULE1
                open_d[ba_s] = 1'b1; // RULE5
              end
              CMD_RD, CMD_WR: begin
                col_d   = addr_s[COL_W-1:0]; // RULE1
                ap_d    = addr_s[A_AUTOPRE]; // RULE1
                bl8_d   = ~chop; // RULE4
                beats_d = chop ? BEATS_BC4 : BEATS_BL8;
                rd_d    = (code == CMD_RD);
                if (addr_s[A_AUTOPRE]) begin
                  open_d[ba_s] = 1'b0;
                end
              end
              default: begin
              end
            endcase
          end
        end
        PW_PD: begin
          cke_d = cke_s;
          if (cke_s) begin
            pw_d = PW_ACT; // RULE10
          end
        end
        PW_SR: begin
        end
        default: pw_d = PW_ACT;
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_MR; i++) begin
        mr_q[i] <= MR_RST;
      end
      open_q       <= OPEN_RST;
      pw_q         <= PW_ACT;
      beats_q      <= 3'h0;
      rd_q         <= 1'b0;
      cke_q        <= 1'b0;
      odt_q        <= 1'b0;
      dqs_q        <= 1'b0;
      ck_prev_q    <= 1'b0;
      cmd_valid    <= 1'b0;
      cmd_code     <= 3'h7;
      cmd_bank     <= '0;
      cmd_row      <= '0;
      cmd_col      <= '0;
      cmd_auto_pre <= 1'b0;
      cmd_bl8      <= 1'b1;
      pre_all      <= 1'b0;
      mr_wr        <= 1'b0;
      wr_store     <= 1'b0;
      wr_masked    <= 1'b0;
    end else begin
      mr_q         <= mr_d;
      open_q       <= open_d;
      pw_q         <= pw_d;
      beats_q      <= beats_d;
      rd_q         <= rd_d;
      cke_q        <= cke_d;
      odt_q        <= odt_d;
      dqs_q        <= dqs_d;
      ck_prev_q    <= ck_s;
      cmd_valid    <= v_d;
      cmd_code     <= code_d;
      cmd_bank     <= bank_d;
      cmd_row      <= row_d;
      cmd_col      <= col_d;
      cmd_auto_pre <= ap_d;
      cmd_bl8      <= bl8_d;
      pre_all      <= pa_d;
      mr_wr        <= mrw_d;
      wr_store     <= ws_d;
      wr_masked    <= wm_d;
    end
  end

  assign open_banks = open_q;
  assign mr_idx     = cmd_bank[1:0];
  assign mr_op      = mr_q[cmd_bank[1:0]];
  assign pwr_state  = pw_q;
  assign cke_int    = cke_q;
  assign odt_on     = odt_q;
  assign dqs        = dqs_q;
  assign dqs_n      = ~dqs_q;
  assign dqs_oe     = rd_q & ((beats_q != 3'h0) | dqs_q); // RULE8

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_act_row: assert property (cmd_valid && cmd_code == CMD_ACT |-> cmd_row == $past(addr_s, 1)) // RULE1
    else $error("row not taken from address");
  chk_pre_all: assert property (cmd_valid && cmd_code == CMD_PRE && pre_all |-> open_q == OPEN_RST) // RULE2
    else $error("precharge all left a bank open");
  chk_mrs_load: assert property (mr_wr |-> mr_op == $past(addr_s, 1) && mr_idx == $past(ba_s[1:0], 1)) // RULE3
    else $error("mode register opcode or index wrong");
  chk_chop_sel: assert property (cmd_valid && cmd_code inside {CMD_RD, CMD_WR} && mr_q[0][1:0] == BL_OTF
                                 |-> cmd_bl8 == $past(addr_s[A_BCHOP], 1)) // RULE4
    else $error("burst chop not taken from A12");
  chk_bank_open: assert property (cmd_valid && cmd_code == CMD_ACT |-> open_q == ($past(open_q, 1) | open_q) && open_q[cmd_bank]) // RULE5
    else $error("activate missed its bank");
  chk_sample_edge: assert property (cmd_valid |-> $past(rise, 1)) // RULE7
    else $error("command taken off a crossing");
  chk_dqs_edge: assert property ($rose(dqs) |-> $past(rise, 1)) // RULE8
    else $error("strobe not aligned to crossing");
  chk_dqs_fall: assert property (fall |=> !dqs) // RULE8
    else $error("strobe not released at falling crossing");
  chk_pd_entry: assert property (pw_q == PW_PD && $past(pw_q, 1) == PW_ACT |-> !cke_int) // RULE9
    else $error("power-down with clock enable high");
  chk_sr_exit: assert property (pw_q == PW_SR && cke_s |=> pw_q == PW_ACT) // RULE10
    else $error("self refresh exit not asynchronous");
  chk_cmd_gate: assert property (cmd_valid |-> $past(pw_q, 1) == PW_ACT && !$past(cs_s, 1)) // RULE11
    else $error("command accepted while gated");
  chk_mask_beat: assert property (wr_store |-> !$past(dm_s, 1) && !wr_masked) // RULE14
    else $error("masked beat stored");
  chk_odt_gate: assert property (odt_on |-> rtt_en && pw_q != PW_SR) // RULE16
    else $error("termination on while disabled");

  cov_act_rd: cover property (cmd_valid && cmd_code == CMD_ACT ##[1:200] cmd_valid && cmd_code == CMD_RD);
  cov_self_ref: cover property (pw_q == PW_SR ##[1:100] pw_q == PW_ACT);
  cov_masked: cover property (wr_masked);
endmodule
`default_nettype wire

// >>> test/ddsc_ctrl_model.sv
// Controller-side model that drives the memory pins of the decoder.
// Assumes clk is the 20 MHz bench clock; ck stands still between commands.
`timescale 1ns/1ps
`default_nettype none
module ddsc_ctrl_model
  import ddsc_pkg::*;
(
  // Clock
  input  wire logic              clk,
  // Memory pins
  output var  logic              ck,
  output var  logic              ck_n,
  output var  logic              cke,
  output var  logic              cs_n,
  output var  logic              ras_n,
  output var  logic              cas_n,
  output var  logic              we_n,
  output var  logic              odt,
  output var  logic              dm,
  output var  logic [BA_W-1:0]   ba,
  output var  logic [ADDR_W-1:0] addr
);
  initial begin
    {ck, odt, dm, ba, addr} = '0;
    {ck_n, cke, cs_n, ras_n, cas_n, we_n} = 6'h3f;
  end
  // ****************************************
  // One ck period of 9 clk per command
  // ****************************************
  task automatic issue(input logic s, input logic [2:0] c, input logic [BA_W-1:0] b,
                       input logic [ADDR_W-1:0] a, input logic e, input logic o,
                       input logic m);
    @(negedge clk);
    cs_n <= s;
    {ras_n, cas_n, we_n} <= s ? ~{ras_n, cas_n, we_n} : c;
    ba <= s ? ~ba : b;
    addr <= s ? ~addr : a;
    cke <= e;
    odt <= o;
    dm <= m;
    repeat (4) @(negedge clk);
    ck <= 1'b1;
    ck_n <= 1'b0;
    repeat (4) @(negedge clk);
    ck <= 1'b0;
    ck_n <= 1'b1;
  endtask
  // Clock enable change with ck still
  task automatic set_cke(input logic e);
    @(negedge clk);
    cke <= e;
  endtask
endmodule
`default_nettype wire

// >>> test/ddsc_top_tb.sv
// Self-checking bench for the memory-side command decoder.
// Assumes the controller model in ddsc_ctrl_model drives every pin.
`timescale 1ns/1ps
`default_nettype none
module ddsc_top_tb
  import ddsc_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, odt, dm;
  logic [BA_W-1:0] ba, cmd_bank;
  logic [ADDR_W-1:0] addr, cmd_row, mr_op;
  logic [2:0] cmd_code;
  logic [COL_W-1:0] cmd_col;
  logic [NUM_BANKS-1:0] open_banks;
  logic [1:0] mr_idx, pwr_state;
  logic cmd_valid, cmd_auto_pre, cmd_bl8, pre_all, mr_wr, cke_int, odt_on;
  logic dqs, dqs_n, dqs_oe, wr_store, wr_masked, dqs_p;
  int fail_count = 0;
  int checks_done = 0;
  int n_val = 0, n_mr = 0, n_st = 0, n_mk = 0, n_dq = 0;
  int v, s, k;
  initial begin
    forever #25 clk = ~clk;
  end
  ddsc_ctrl_model i_ddsc_ctrl_model (.clk(clk), .ck(ck), .ck_n(ck_n), .cke(cke),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .odt(odt), .dm(dm),
    .ba(ba), .addr(addr));
  ddsc_top i_ddsc_top (.clk(clk), .resetn(resetn), .ck(ck), .ck_n(ck_n), .cke(cke),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .odt(odt), .dm(dm),
    .ba(ba), .addr(addr), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_bank(cmd_bank), .cmd_row(cmd_row), .cmd_col(cmd_col),
    .cmd_auto_pre(cmd_auto_pre), .cmd_bl8(cmd_bl8), .pre_all(pre_all),
    .open_banks(open_banks), .mr_wr(mr_wr), .mr_idx(mr_idx), .mr_op(mr_op),
    .pwr_state(pwr_state), .cke_int(cke_int), .odt_on(odt_on), .dqs(dqs),
    .dqs_n(dqs_n), .dqs_oe(dqs_oe), .wr_store(wr_store), .wr_masked(wr_masked));
  // ****************************************
  // Pulse counters
  // ****************************************
  always @(posedge clk) begin
    dqs_p <= dqs;
    if (cmd_valid === 1'b1) n_val++;
    if (mr_wr === 1'b1) n_mr++;
    if (wr_store === 1'b1) n_st++;
    if (wr_masked === 1'b1) n_mk++;
    if (dqs === 1'b1 && dqs_p === 1'b0) n_dq++;
  end
  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic go(input logic [2:0] c, input logic [2:0] b, input logic [15:0] a);
    i_ddsc_ctrl_model.issue(1'b0, c, b, a, 1'b1, 1'b0, 1'b0);
  endtask
  task automatic nop(input logic e, input logic o, input logic m);
    i_ddsc_ctrl_model.issue(1'b0, CMD_NOP, 3'h0, 16'h0000, e, o, m);
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    chk(cmd_code, CMD_NOP);
    chk(open_banks, OPEN_RST);
    chk(pwr_state, PW_ACT);
    chk(odt_on, 1'b0);
    chk({dqs_oe, dqs_n}, 2'h1);
    $display("test reset done");
  endtask
  task automatic t_act_pre();
    v = n_val;
    go(CMD_ACT, 3'h3, 16'h1234);
    chk(n_val - v, 16'h0001);
    chk(cmd_code, CMD_ACT);
    chk(cmd_row, 16'h1234);
    chk(cmd_bank, 3'h3);
    go(CMD_ACT, 3'h5, 16'h0abc);
    chk(open_banks, 8'h28);
    go(CMD_PRE, 3'h3, 16'h0000);
    chk({pre_all, open_banks}, 9'h020);
    go(CMD_PRE, 3'h0, 16'h0400);
    chk({pre_all, open_banks}, 9'h100);
    $display("test activate precharge done");
  endtask
  task automatic t_mrs();
    logic [15:0] op [4] = '{16'h0001, 16'h0004, 16'h0208, 16'h0003};
    for (int i = 0; i < 4; i++) begin
      v = n_mr;
      go(CMD_MRS, i[2:0], op[i]);
      chk(n_mr - v, 16'h0001);
      chk(mr_idx, i[1:0]);
      chk(mr_op, op[i]);
    end
    $display("test mode load done");
  endtask
  task automatic t_rdwr();
    go(CMD_WR, 3'h1, 16'h1155);
    chk({cmd_code, cmd_bl8, cmd_auto_pre}, {CMD_WR, 2'h2});
    chk(cmd_col, 10'h155);
    s = n_st;
    k = n_mk;
    for (int i = 0; i < 5; i++) nop(1'b1, 1'b0, i[0]);
    chk(n_st - s, 16'h0002);
    chk(n_mk - k, 16'h0002);
    go(CMD_ACT, 3'h2, 16'h0007);
    go(CMD_RD, 3'h2, 16'h0420);
    chk({cmd_bl8, cmd_auto_pre}, 2'h1);
    chk(open_banks, 8'h00);
    v = n_dq;
    for (int i = 0; i < 3; i++) nop(1'b1, 1'b0, 1'b0);
    chk(n_dq - v, 16'h0002);
    chk(dqs_oe, 1'b0);
    chk(dqs, 1'b0);
    go(CMD_MRS, 3'h0, 16'h0002);
    go(CMD_WR, 3'h1, 16'h1000);
    chk(cmd_bl8, 1'b0);
    go(CMD_MRS, 3'h0, 16'h0000);
    go(CMD_WR, 3'h1, 16'h0000);
    chk(cmd_bl8, 1'b1);
    $display("test read write done");
  endtask
  task automatic t_cs();
    v = n_val;
    i_ddsc_ctrl_model.issue(1'b1, CMD_ACT, 3'h6, 16'h0001, 1'b1, 1'b0, 1'b0);
    chk(n_val - v, 16'h0000);
    chk(open_banks, 8'h00);
    $display("test chip select done");
  endtask
  task automatic t_odt();
    nop(1'b1, 1'b1, 1'b0);
    chk(odt_on, 1'b1);
    nop(1'b1, 1'b0, 1'b0);
    chk(odt_on, 1'b0);
    go(CMD_MRS, 3'h1, 16'h0000);
    nop(1'b1, 1'b1, 1'b0);
    chk(odt_on, 1'b0);
    $display("test termination done");
  endtask
  task automatic t_power();
    nop(1'b0, 1'b0, 1'b0);
    chk({pwr_state, cke_int}, {PW_PD, 1'b0});
    v = n_val;
    i_ddsc_ctrl_model.issue(1'b0, CMD_ACT, 3'h4, 16'h0002, 1'b0, 1'b0, 1'b0);
    chk(n_val - v, 16'h0000);
    nop(1'b1, 1'b0, 1'b0);
    chk(pwr_state, PW_ACT);
    i_ddsc_ctrl_model.issue(1'b0, CMD_REF, 3'h0, 16'h0000, 1'b0, 1'b0, 1'b0);
    chk(pwr_state, PW_SR);
    i_ddsc_ctrl_model.set_cke(1'b1);
    repeat (6) @(negedge clk);
    chk(pwr_state, PW_ACT);
    $display("test power done");
  endtask
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    repeat (8) @(negedge clk);
    resetn <= 1'b1;
    repeat (2) @(negedge clk);
    t_reset();
    t_act_pre();
    t_mrs();
    t_rdwr();
    t_cs();
    t_odt();
    t_power();
    finish_test();
  end
  initial begin
    #200us;
    fail_count++;
    finish_test();
  end
endmodule
`default_nettype wire
